// File: inc/lnh_regs.svh
// timing constants and widths for the lin transceiver host controller
`ifndef LNH_REGS_SVH
`define LNH_REGS_SVH

// ----------------------------------------------------------------------
// clock
// ----------------------------------------------------------------------
`define LNH_CLK_MHZ                      100

// ----------------------------------------------------------------------
// times in their own units
// ----------------------------------------------------------------------
`define LNH_SLEEP_ENTRY_DELAY_US         50
`define LNH_SELECTION_SETUP_TIME_NS      5000
`define LNH_FIRST_TRANSMIT_DELAY_US      50
`define LNH_TOGGLE_WINDOW_US             35
`define LNH_FAST_EXIT_GLITCH_WINDOW_NS   5000
`define LNH_TOGGLE_STEP_US               10
`define LNH_GLITCH_PULSE_US              2

// ----------------------------------------------------------------------
// cycle counts (least times rounded up, longest rounded down)
// ----------------------------------------------------------------------
`define LNH_SETUP_CYC \
   ((`LNH_SELECTION_SETUP_TIME_NS * `LNH_CLK_MHZ + 999) / 1000)
`define LNH_TOGGLE_MAX_CYC   (`LNH_TOGGLE_WINDOW_US * `LNH_CLK_MHZ)
`define LNH_GLITCH_MAX_CYC \
   ((`LNH_FAST_EXIT_GLITCH_WINDOW_NS * `LNH_CLK_MHZ) / 1000)
`define LNH_TOGGLE_STEP_CYC  (`LNH_TOGGLE_STEP_US * `LNH_CLK_MHZ)
`define LNH_GLITCH_CYC       (`LNH_GLITCH_PULSE_US * `LNH_CLK_MHZ)

// ----------------------------------------------------------------------
// widths and reset levels
// ----------------------------------------------------------------------
`define LNH_TMR_W            13
`define LNH_MON_W            16
`define LNH_TXD_IDLE         1'h1
`define LNH_RXD_IDLE         1'h1

`endif

// File: inc/lnh_pkg.sv
// types for the lin transceiver host controller
`include "lnh_regs.svh"

package lnh_pkg;

   typedef logic [`LNH_TMR_W-1:0] lnh_tmr_t;
   typedef logic [`LNH_MON_W-1:0] lnh_mon_t;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_SETUP,
      ST_SETTLE,
      ST_ACTIVE,
      ST_SLEEP_HOLD,
      ST_TOG_LOW,
      ST_TOG_TXH,
      ST_GLITCH
   } lnh_state_t;

   typedef enum logic [2:0] {
      CMD_WAKE_NORMAL,
      CMD_WAKE_SLOW,
      CMD_SLEEP,
      CMD_FAST_ENTER,
      CMD_FAST_EXIT
   } lnh_cmd_t;

   typedef enum logic [1:0] {
      MODE_OFF,
      MODE_NORMAL,
      MODE_SLOW,
      MODE_FAST
   } lnh_mode_t;

   typedef struct packed {
      lnh_state_t state;
      lnh_mode_t  mode;
      lnh_mode_t  base;
      logic       en;
      logic       txd;
      logic       rx_bit;
      logic       wake_seen;
      logic       reject;
      lnh_mon_t   en_low_cyc;
      lnh_mon_t   en_high_cyc;
      lnh_mon_t   txd_stable_cyc;
   } lnh_ctl_t;

   typedef struct packed {
      lnh_tmr_t cnt;
   } lnh_tmr_st_t;

endpackage

// File: core/lnh_timer.sv
// down-counting delay timer used to measure every pin window
`timescale 1ns/100ps
`include "lnh_regs.svh"

module lnh_timer (
   input  wire logic             i_core_clk,
   input  wire logic             i_sys_rst,
   input  wire logic             i_load,
   input  wire lnh_pkg::lnh_tmr_t i_count,
   output logic                  o_done
);

   lnh_pkg::lnh_tmr_st_t st_reg;
   lnh_pkg::lnh_tmr_st_t st_next;

   always_comb begin
      st_next = st_reg;
      if (i_load) begin
         st_next.cnt = i_count;
      end else if (st_reg.cnt != '0) begin
         st_next.cnt = st_reg.cnt - lnh_pkg::lnh_tmr_t'(1);
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // done is read only in states entered with a fresh load, so it needs
   // no load term; one would close a loop through the sequencer's load
   assign o_done = (st_reg.cnt == '0);

   a_timer_counts_down: assert property (
      @(posedge i_core_clk) disable iff (i_sys_rst)
      (!i_load && st_reg.cnt != '0) |=> (st_reg.cnt == $past(st_reg.cnt) - 1)
   ) else $error("timer did not count down by one");

endmodule

// File: core/lnh_host.sv
// host-side controller driving transmit and mode control pins of a lin phy
`timescale 1ns/100ps
`include "lnh_regs.svh"

// Overview of operation
// - host holds mode control low at least 50 us to request sleep.
// - host sets transmit level 5.0 us before raising mode control.
// - host waits 50 us after mode selection before first data edge.
// - fast toggle, mode low to mode high, finishes within 35 us.
// - sleep requested by mode control low while transmit is high.
// - toggle: both low, transmit high, then mode high enters fast.
module lnh_host #(
   parameter int unsigned P_SLEEP_ENTRY_CYC =
      `LNH_SLEEP_ENTRY_DELAY_US * `LNH_CLK_MHZ,
   parameter int unsigned P_FIRST_TRANSMIT_CYC =
      `LNH_FIRST_TRANSMIT_DELAY_US * `LNH_CLK_MHZ
) (
   input  wire logic              i_core_clk,
   input  wire logic              i_sys_rst,
   input  wire logic              i_cmd_valid,
   input  wire lnh_pkg::lnh_cmd_t i_cmd,
   output logic                   o_cmd_ready,
   output logic                   o_cmd_reject,
   input  wire logic              i_tx_bit,
   output logic                   o_tx_ready,
   input  wire logic              i_rxd,
   output logic                   o_rx_bit,
   output logic                   o_wake_seen,
   output lnh_pkg::lnh_mode_t     o_mode,
   output logic                   o_en,
   output logic                   o_txd
);

   // -------------------------------------------------------------------
   // state and timer
   // -------------------------------------------------------------------
   lnh_pkg::lnh_ctl_t ctl_reg;
   lnh_pkg::lnh_ctl_t ctl_next;
   logic              tmr_load;
   lnh_pkg::lnh_tmr_t tmr_count;
   logic              tmr_done;

   lnh_timer i_lnh_timer (
      .i_core_clk (i_core_clk),
      .i_sys_rst  (i_sys_rst),
      .i_load     (tmr_load),
      .i_count    (tmr_count),
      .o_done     (tmr_done)
   );

   function automatic lnh_pkg::lnh_mon_t sat_inc(lnh_pkg::lnh_mon_t v);
      sat_inc = (v == '1) ? v : v + lnh_pkg::lnh_mon_t'(1);
   endfunction

   // -------------------------------------------------------------------
   // sequencer
   // -------------------------------------------------------------------
   always_comb begin
      ctl_next = ctl_reg;
      ctl_next.reject = 1'h0;
      tmr_load = 1'h0;
      tmr_count = '0;
      ctl_next.rx_bit = i_rxd;
      // rxd low while the host is idle is the phy's wake report
      ctl_next.wake_seen = (ctl_reg.state == lnh_pkg::ST_IDLE) && !i_rxd;
      case (ctl_reg.state)
         lnh_pkg::ST_IDLE: begin
            if (i_cmd_valid) begin
               if (i_cmd == lnh_pkg::CMD_WAKE_NORMAL ||
                   i_cmd == lnh_pkg::CMD_WAKE_SLOW) begin
                  ctl_next.state = lnh_pkg::ST_SETUP;
                  // high selects normal, low selects slow
                  ctl_next.txd = (i_cmd == lnh_pkg::CMD_WAKE_NORMAL);
                  ctl_next.base = (i_cmd == lnh_pkg::CMD_WAKE_NORMAL) ?
                     lnh_pkg::MODE_NORMAL : lnh_pkg::MODE_SLOW;
                  tmr_load = 1'h1;
                  tmr_count = lnh_pkg::lnh_tmr_t'(`LNH_SETUP_CYC);
               end else begin
                  ctl_next.reject = 1'h1;
               end
            end
         end
         lnh_pkg::ST_SETUP: begin
            if (tmr_done) begin
               ctl_next.en = 1'h1;
               ctl_next.mode = ctl_reg.base;
               ctl_next.state = lnh_pkg::ST_SETTLE;
               tmr_load = 1'h1;
               tmr_count = lnh_pkg::lnh_tmr_t'(P_FIRST_TRANSMIT_CYC);
            end
         end
         lnh_pkg::ST_SETTLE: begin
            // transmit held at its selection level until the wait ends
            if (tmr_done) begin
               ctl_next.state = lnh_pkg::ST_ACTIVE;
            end
         end
         lnh_pkg::ST_ACTIVE: begin
            ctl_next.txd = i_tx_bit;
            if (i_cmd_valid) begin
               case (i_cmd)
                  lnh_pkg::CMD_SLEEP: begin
                     ctl_next.state = lnh_pkg::ST_SLEEP_HOLD;
                     ctl_next.en = 1'h0;
                     ctl_next.txd = 1'h1;
                     tmr_load = 1'h1;
                     tmr_count = lnh_pkg::lnh_tmr_t'(P_SLEEP_ENTRY_CYC);
                  end
                  lnh_pkg::CMD_FAST_ENTER: begin
                     if (ctl_reg.mode != lnh_pkg::MODE_FAST) begin
                        ctl_next.state = lnh_pkg::ST_TOG_LOW;
                        ctl_next.en = 1'h0;
                        ctl_next.txd = 1'h0;
                        tmr_load = 1'h1;
                        tmr_count =
                           lnh_pkg::lnh_tmr_t'(`LNH_TOGGLE_STEP_CYC);
                     end else begin
                        ctl_next.reject = 1'h1;
                     end
                  end
                  lnh_pkg::CMD_FAST_EXIT: begin
                     if (ctl_reg.mode == lnh_pkg::MODE_FAST) begin
                        ctl_next.state = lnh_pkg::ST_GLITCH;
                        ctl_next.en = 1'h0;
                        ctl_next.txd = 1'h1;
                        tmr_load = 1'h1;
                        tmr_count =
                           lnh_pkg::lnh_tmr_t'(`LNH_GLITCH_CYC);
                     end else begin
                        ctl_next.reject = 1'h1;
                     end
                  end
                  // rate is locked until the phy has slept
                  default: ctl_next.reject = 1'h1;
               endcase
            end
         end
         lnh_pkg::ST_SLEEP_HOLD: begin
            if (tmr_done) begin
               ctl_next.state = lnh_pkg::ST_IDLE;
               ctl_next.mode = lnh_pkg::MODE_OFF;
            end
         end
         lnh_pkg::ST_TOG_LOW: begin
            if (tmr_done) begin
               ctl_next.state = lnh_pkg::ST_TOG_TXH;
               ctl_next.txd = 1'h1;
               tmr_load = 1'h1;
               tmr_count = lnh_pkg::lnh_tmr_t'(`LNH_TOGGLE_STEP_CYC);
            end
         end
         lnh_pkg::ST_TOG_TXH: begin
            if (tmr_done) begin
               ctl_next.state = lnh_pkg::ST_SETTLE;
               ctl_next.en = 1'h1;
               ctl_next.mode = lnh_pkg::MODE_FAST;
               tmr_load = 1'h1;
               tmr_count = lnh_pkg::lnh_tmr_t'(P_FIRST_TRANSMIT_CYC);
            end
         end
         lnh_pkg::ST_GLITCH: begin
            if (tmr_done) begin
               ctl_next.state = lnh_pkg::ST_SETTLE;
               ctl_next.en = 1'h1;
               ctl_next.mode = ctl_reg.base;
               tmr_load = 1'h1;
               tmr_count = lnh_pkg::lnh_tmr_t'(P_FIRST_TRANSMIT_CYC);
            end
         end
         default: ctl_next.state = lnh_pkg::ST_IDLE;
      endcase
      // pin history, kept so the timing checks can see it
      ctl_next.en_low_cyc = ctl_reg.en ? '0 : sat_inc(ctl_reg.en_low_cyc);
      ctl_next.en_high_cyc = ctl_reg.en ? sat_inc(ctl_reg.en_high_cyc) : '0;
      ctl_next.txd_stable_cyc = (ctl_next.txd != ctl_reg.txd) ? '0 :
         sat_inc(ctl_reg.txd_stable_cyc);
   end

   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         ctl_reg <= '0;
         ctl_reg.state <= lnh_pkg::ST_IDLE;
         ctl_reg.mode <= lnh_pkg::MODE_OFF;
         ctl_reg.base <= lnh_pkg::MODE_OFF;
         ctl_reg.txd <= `LNH_TXD_IDLE;
         ctl_reg.rx_bit <= `LNH_RXD_IDLE;
      end else begin
         ctl_reg <= ctl_next;
      end
   end

   // -------------------------------------------------------------------
   // outputs
   // -------------------------------------------------------------------
   assign o_cmd_ready = (ctl_reg.state == lnh_pkg::ST_IDLE) ||
                        (ctl_reg.state == lnh_pkg::ST_ACTIVE);
   assign o_tx_ready = (ctl_reg.state == lnh_pkg::ST_ACTIVE);
   assign o_cmd_reject = ctl_reg.reject;
   assign o_rx_bit = ctl_reg.rx_bit;
   assign o_wake_seen = ctl_reg.wake_seen;
   assign o_mode = ctl_reg.mode;
   assign o_en = ctl_reg.en;
   assign o_txd = ctl_reg.txd;

   // -------------------------------------------------------------------
   // checks
   // -------------------------------------------------------------------
   a_sleep_hold_len: assert property (
      @(posedge i_core_clk) disable iff (i_sys_rst)
      (ctl_reg.state == lnh_pkg::ST_SLEEP_HOLD && tmr_done) |->
         (ctl_reg.en_low_cyc >= P_SLEEP_ENTRY_CYC)
   ) else $error("sleep request released too early");

   a_setup_before_en: assert property (
      @(posedge i_core_clk) disable iff (i_sys_rst)
      ($rose(ctl_reg.en) && $past(ctl_reg.state) == lnh_pkg::ST_SETUP) |->
         (ctl_reg.txd_stable_cyc >= `LNH_SETUP_CYC)
   ) else $error("transmit level not set up before mode rise");

   a_first_tx_wait: assert property (
      @(posedge i_core_clk) disable iff (i_sys_rst)
      ($changed(ctl_reg.txd) && ctl_reg.en && $past(ctl_reg.en)) |->
         (ctl_reg.en_high_cyc >= P_FIRST_TRANSMIT_CYC)
   ) else $error("data edge before first transmit delay");

   a_toggle_window: assert property (
      @(posedge i_core_clk) disable iff (i_sys_rst)
      ($rose(ctl_reg.en) && $past(ctl_reg.state) == lnh_pkg::ST_TOG_TXH)
         |-> (ctl_reg.en_low_cyc < `LNH_TOGGLE_MAX_CYC)
   ) else $error("toggle sequence too long");

   a_toggle_start: assert property (
      @(posedge i_core_clk) disable iff (i_sys_rst)
      ($fell(ctl_reg.en) && ctl_reg.state == lnh_pkg::ST_TOG_LOW) |->
         !ctl_reg.txd
   ) else $error("toggle did not start with both pins low");

   // each step outlasts a delay range, so the pin history proves order
   a_toggle_order: assert property (
      @(posedge i_core_clk) disable iff (i_sys_rst)
      ($rose(ctl_reg.en) && $past(ctl_reg.state) == lnh_pkg::ST_TOG_TXH)
         |-> ctl_reg.txd && (ctl_reg.txd_stable_cyc != '0) &&
         (ctl_reg.txd_stable_cyc < ctl_reg.en_low_cyc) &&
         (ctl_reg.mode == lnh_pkg::MODE_FAST)
   ) else $error("toggle steps out of order");

   a_glitch_short: assert property (
      @(posedge i_core_clk) disable iff (i_sys_rst)
      ($rose(ctl_reg.en) && $past(ctl_reg.state) == lnh_pkg::ST_GLITCH) |->
         (ctl_reg.en_low_cyc < `LNH_GLITCH_MAX_CYC) &&
         (ctl_reg.mode == ctl_reg.base)
   ) else $error("fast exit pulse too long or wrong mode");

   a_sleep_txd_high: assert property (
      @(posedge i_core_clk) disable iff (i_sys_rst)
      (ctl_reg.state == lnh_pkg::ST_ACTIVE && i_cmd_valid &&
       i_cmd == lnh_pkg::CMD_SLEEP) |=>
         (!ctl_reg.en && ctl_reg.txd) throughout
         (ctl_reg.state == lnh_pkg::ST_SLEEP_HOLD) [*8]
   ) else $error("sleep request without transmit high");

   a_rate_lock: assert property (
      @(posedge i_core_clk) disable iff (i_sys_rst)
      (ctl_reg.state == lnh_pkg::ST_ACTIVE && i_cmd_valid &&
       (i_cmd == lnh_pkg::CMD_WAKE_NORMAL ||
        i_cmd == lnh_pkg::CMD_WAKE_SLOW)) |=>
         ($stable(ctl_reg.base) && ctl_reg.reject)
   ) else $error("rate changed without sleep");

endmodule

// File: verif/lnh_phy_model.sv
// behavioural model of the lin phy pins that face the host controller
`timescale 1ns/100ps

module lnh_phy_model #(
   parameter int unsigned P_SLEEP_CYC  = 5000,
   parameter int unsigned P_TOGGLE_CYC = 3500,
   parameter int unsigned P_GLITCH_CYC = 500,
   parameter int unsigned P_LSW_CYC    = 1000,
   parameter int unsigned P_BUS_CYC    = 4000
) (
   input  wire logic  i_core_clk,
   input  wire logic  i_sys_rst,
   input  wire logic  i_en,
   input  wire logic  i_txd,
   input  wire logic  i_lsw,
   input  wire logic  i_remote_dom,
   output wire logic  o_rxd,
   output logic       o_inh,
   output logic       o_bus,
   output logic [1:0] o_slew,
   output logic       o_asleep
);
   logic        awake_reg;
   logic        en_reg;
   logic        txd_reg;
   logic        tog_reg;
   logic        ref_reg;
   logic [1:0]  base_reg;
   int unsigned low_cnt;
   int unsigned lsw_cnt;
   int unsigned dom_cnt;

   // transmit path only opens with a rate chosen and enable high
   assign o_bus = !((o_slew != 2'h0 && i_en && !i_txd) || i_remote_dom);
   assign o_rxd = o_asleep ? 1'bz : (awake_reg ? 1'b0 : o_bus);

   always_ff @(posedge i_core_clk) begin
      en_reg <= i_en;
      txd_reg <= i_txd;
      if (i_sys_rst) begin
         {o_asleep, o_slew, base_reg, tog_reg, ref_reg} <= '0;
         awake_reg <= 1'b1;
         o_inh <= 1'b1;
         low_cnt <= 0;
         lsw_cnt <= 0;
         dom_cnt <= 0;
      end else begin
         low_cnt <= i_en ? 0 : low_cnt + 1;
         lsw_cnt <= (o_asleep && i_lsw != ref_reg) ? lsw_cnt + 1 : 0;
         dom_cnt <= (o_asleep && i_remote_dom) ? dom_cnt + 1 : 0;
         if (!i_en && en_reg)
            tog_reg <= !i_txd;
         if (i_en && !en_reg) begin
            if (o_asleep || awake_reg) begin
               base_reg <= txd_reg ? 2'h1 : 2'h2;
               o_slew <= txd_reg ? 2'h1 : 2'h2;
               o_asleep <= 1'b0;
               awake_reg <= 1'b0;
               o_inh <= 1'b1;
            end else if (o_slew == 2'h3 && low_cnt < P_GLITCH_CYC)
               o_slew <= base_reg;
            else if (tog_reg && txd_reg && low_cnt < P_TOGGLE_CYC)
               o_slew <= (o_slew == 2'h3) ? base_reg : 2'h3;
         end
         // awake-but-unselected stays awake until the host picks a rate
         if (!i_en && i_txd && low_cnt == P_SLEEP_CYC - 1 &&
             !o_asleep && !awake_reg) begin
            o_asleep <= 1'b1;
            o_slew <= 2'h0;
            o_inh <= 1'b0;
            ref_reg <= i_lsw;
         end
         if (lsw_cnt == P_LSW_CYC - 1 || dom_cnt == P_BUS_CYC - 1) begin
            o_asleep <= 1'b0;
            awake_reg <= 1'b1;
            o_inh <= 1'b1;
         end
      end
   end
endmodule

// File: verif/tb_lnh_host.sv
// self-checking bench for the lin transceiver host controller
`timescale 1ns/100ps

module tb_lnh_host;
   localparam int C_SLEEP = 5000;
   localparam int C_FIRST = 5000;
   logic               clk;
   logic               rst;
   logic               cmd_valid;
   lnh_pkg::lnh_cmd_t  cmd;
   logic               cmd_ready;
   logic               cmd_reject;
   logic               tx_bit;
   logic               tx_ready;
   tri1                rxd;
   logic               rx_bit;
   logic               wake_seen;
   lnh_pkg::lnh_mode_t mode;
   logic               en;
   logic               txd;
   logic               lsw;
   logic               remote;
   logic               supply_switch_output;
   logic               bus;
   logic [1:0]         slew;
   logic               asleep;
   logic               rej;
   logic               t0;
   logic               t1;
   int                 mismatches;
   int                 checks_done;
   int                 n;
   int                 lo;
   int                 inh_at;

   lnh_host #(.P_SLEEP_ENTRY_CYC(C_SLEEP), .P_FIRST_TRANSMIT_CYC(C_FIRST))
   i_lnh_host (.i_core_clk(clk), .i_sys_rst(rst), .i_cmd_valid(cmd_valid),
      .i_cmd(cmd), .o_cmd_ready(cmd_ready), .o_cmd_reject(cmd_reject),
      .i_tx_bit(tx_bit), .o_tx_ready(tx_ready), .i_rxd(rxd),
      .o_rx_bit(rx_bit), .o_wake_seen(wake_seen), .o_mode(mode),
      .o_en(en), .o_txd(txd));

   lnh_phy_model i_lnh_phy_model (.i_core_clk(clk), .i_sys_rst(rst),
      .i_en(en), .i_txd(txd), .i_lsw(lsw), .i_remote_dom(remote),
      .o_rxd(rxd), .o_inh(supply_switch_output), .o_bus(bus), .o_slew(slew),
      .o_asleep(asleep));

   // ------------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------------
   task results;
      if (mismatches == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task chk(input logic ok, input string msg);
      checks_done++;
      if (ok !== 1'b1) begin
         mismatches++;
         $display("[FAIL] %0t %s", $time, msg);
      end
   endtask

   // one cycle of a bounded wait; a hang ends the run
   task step(input int lim);
      @(negedge clk);
      n++;
      if (n > lim) begin
         chk(1'b0, "wait limit reached");
         results();
      end
   endtask

   task send(input lnh_pkg::lnh_cmd_t c);
      n = 0;
      while (cmd_ready !== 1'b1) step(9000);
      cmd_valid = 1'b1;
      cmd = c;
      @(negedge clk);
      cmd_valid = 1'b0;
      rej = cmd_reject;
   endtask

   task refuse(input lnh_pkg::lnh_cmd_t c);
      send(c);
      @(negedge clk);
      chk(rej === 1'b1 && cmd_reject === 1'b0, "refusal wrong");
   endtask

   // length of one enable-low phase, with transmit level at its ends
   task watch_low;
      n = 0;
      while (en !== 1'b0) step(20);
      t0 = txd;
      lo = 0;
      inh_at = 0;
      while (en === 1'b0 && cmd_ready !== 1'b1) begin
         t1 = txd;
         if (supply_switch_output === 1'b1)
            inh_at = lo + 1;
         lo++;
         step(9000);
      end
   endtask

   task wait_tx;
      n = 0;
      while (tx_ready !== 1'b1) step(C_FIRST + 100);
   endtask

   // ------------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------------
   task t_wake(input lnh_pkg::lnh_cmd_t c, input logic lvl,
               input logic [1:0] s, input lnh_pkg::lnh_mode_t m);
      int st;
      int fc;
      st = 0;
      fc = 0;
      send(c);
      n = 0;
      while (en !== 1'b1) begin
         st = (txd === lvl) ? st + 1 : 0;
         step(2000);
      end
      chk(st >= 500, "level not set up before enable");
      @(negedge clk);
      chk(slew === s && mode === m, "rate selection wrong");
      tx_bit = !lvl;
      n = 0;
      while (txd === lvl) begin
         fc++;
         step(C_FIRST + 100);
      end
      chk(fc >= C_FIRST - 1 && tx_ready === 1'b1, "first data too early");
   endtask

   task t_data;
      logic [3:0] pat;
      pat = 4'h5;
      for (int i = 0; i < 4; i++) begin
         tx_bit = pat[i];
         @(negedge clk);
         @(negedge clk);
         chk(txd === pat[i] && bus === pat[i], "bus not following data");
         chk(rx_bit === pat[i], "receive bit wrong");
      end
      tx_bit = 1'b1;
   endtask

   task t_fast(input logic [1:0] s, input lnh_pkg::lnh_mode_t m);
      send(lnh_pkg::CMD_FAST_ENTER);
      watch_low();
      chk(lo < 3500 && t0 === 1'b0 && t1 === 1'b1, "toggle shape wrong");
      @(negedge clk);
      chk(slew === 2'h3 && mode === lnh_pkg::MODE_FAST, "fast not entered");
      wait_tx();
      refuse(lnh_pkg::CMD_FAST_ENTER);
      send(lnh_pkg::CMD_FAST_EXIT);
      watch_low();
      chk(lo < 500 && t0 === 1'b1, "exit pulse too long");
      @(negedge clk);
      chk(slew === s && mode === m, "rate not restored");
      wait_tx();
   endtask

   task t_sleep;
      send(lnh_pkg::CMD_SLEEP);
      watch_low();
      chk(lo >= C_SLEEP && t0 === 1'b1 && t1 === 1'b1, "short sleep request");
      chk(inh_at <= C_SLEEP && supply_switch_output === 1'b0 && asleep === 1'b1, "supply on");
      @(negedge clk);
      chk(rx_bit === 1'b1 && wake_seen === 1'b0, "rxd not released");
      chk(mode === lnh_pkg::MODE_OFF && cmd_ready === 1'b1, "host not idle");
   endtask

   task t_local_wake;
      lsw = !lsw;
      repeat (500) @(negedge clk);
      lsw = !lsw;
      // let the return to the reference level reach the filter first
      repeat (2) @(negedge clk);
      chk(asleep === 1'b1, "short switch pulse woke the phy");
      lsw = !lsw;
      n = 0;
      while (wake_seen !== 1'b1) step(1500);
      chk(n >= 1000 && supply_switch_output === 1'b1, "local wake wrong");
   endtask

   task t_bus_wake;
      remote = 1'b1;
      n = 0;
      while (wake_seen !== 1'b1) step(5000);
      remote = 1'b0;
      chk(n >= 4000 && supply_switch_output === 1'b1, "bus wake wrong");
   endtask

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   initial begin
      rst = 1'b1;
      cmd_valid = 1'b0;
      cmd = lnh_pkg::CMD_SLEEP;
      tx_bit = 1'b1;
      lsw = 1'b0;
      remote = 1'b0;
      mismatches = 0;
      checks_done = 0;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      chk(en === 1'b0 && txd === 1'b1 && tx_ready === 1'b0, "reset");
      chk(supply_switch_output === 1'b1 && mode === lnh_pkg::MODE_OFF, "power-up state");
      t_wake(lnh_pkg::CMD_WAKE_NORMAL, 1'b1, 2'h1, lnh_pkg::MODE_NORMAL);
      t_data();
      refuse(lnh_pkg::CMD_WAKE_SLOW);
      refuse(lnh_pkg::CMD_FAST_EXIT);
      t_fast(2'h1, lnh_pkg::MODE_NORMAL);
      t_sleep();
      t_local_wake();
      t_wake(lnh_pkg::CMD_WAKE_SLOW, 1'b0, 2'h2, lnh_pkg::MODE_SLOW);
      t_data();
      t_fast(2'h2, lnh_pkg::MODE_SLOW);
      t_sleep();
      t_bus_wake();
      t_wake(lnh_pkg::CMD_WAKE_NORMAL, 1'b1, 2'h1, lnh_pkg::MODE_NORMAL);
      t_sleep();
      t_local_wake();
      results();
   end
endmodule
